// >>> src/bli_pkg.sv
// Package for the backlight interrupt and configuration block.
// Assumes a byte-wide register port decoded by an upstream serial slave.
`default_nettype none
package bli_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h03;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	// Event bit positions, shared by status and enable registers
	localparam int BIT_MAIN_SENSOR   = 0;
	localparam int BIT_SECOND_SENSOR = 1;
	localparam int BIT_OVERVOLTAGE   = 2;
	localparam int BIT_THERMAL       = 3;
	localparam int BIT_SHORT         = 4;
	localparam int BIT_FADE_DONE     = 5;
	localparam int NUM_EVENTS        = 6;
	// Configuration field positions
	localparam int CFG_SOURCE_SEL  = 7;
	localparam int CFG_SECOND_EN   = 6;
	localparam int CFG_LEVEL_HI    = 5;
	localparam int CFG_LEVEL_LO    = 3;
	localparam int CFG_LAW_HI      = 2;
	localparam int CFG_LAW_LO      = 1;
	localparam int CFG_FADE_OVR    = 0;
	// Reset values
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_IRQ_EN = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	// Highest valid brightness code (dark); above it the current is zero
	localparam logic [2:0] LEVEL_MAX = 3'h4;
	localparam logic [7:0] EVENT_MASK = 8'h3F;
endpackage
`default_nettype wire

// >>> src/bli_irq_cfg.sv
// Interrupt flags, enables and backlight configuration register.
// Assumes event inputs are one-cycle pulses on sys_clk_i and a same-clock register port.
`default_nettype none

// Overview of operation
// [R1] Fade-done enable bit 5 gates interrupt
// [R2] Auto fade-out or profile end sets fade-done
// [R3] Short enable bit 4 gates short interrupt
// [R4] Thermal enable bit 3 gates thermal interrupt
// [R5] Overvoltage enable bit 2 gates interrupt
// [R6] Second sensor enable bit 1 gates interrupt
// [R7] Main sensor enable bit 0 gates interrupt
// [R8] Interrupt is OR of enabled set flags
// [R9] Write one clears flag; reads harmless
// [R10] Config bit 7 selects controlling sensor
// [R11] Config bit 6 trades sensor two for sink six
// [R12] Level codes above 100 give zero current
module bli_irq_cfg (
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       auto_fade_done_i,
	input  wire logic       profile_done_i,
	input  wire logic       short_fault_i,
	input  wire logic       thermal_trip_i,
	input  wire logic       overvoltage_i,
	input  wire logic       second_sensor_trip_i,
	input  wire logic       main_sensor_trip_i,
	output logic            host_irq_o,
	output logic      [7:0] status_o,
	output logic            sensor_source_select_o,
	output logic            second_sensor_enable_o,
	output logic            sixth_led_sink_enable_o,
	output logic      [2:0] brightness_level_select_o,
	output logic            backlight_off_o,
	output logic      [1:0] dimming_transfer_law_o,
	output logic            fade_override_o
);
	import bli_pkg::*;

	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] irq_en_q;
	logic [7:0] config_q;
	logic [7:0] events;
	logic       irq_d;

	// Gather event sources into flag positions
	always_comb begin
		events = 8'h00;
		events[BIT_FADE_DONE]     = auto_fade_done_i | profile_done_i; // [R2]
		events[BIT_SHORT]         = short_fault_i;
		events[BIT_THERMAL]       = thermal_trip_i;
		events[BIT_OVERVOLTAGE]   = overvoltage_i;
		// A disabled second sensor cannot trip
		events[BIT_SECOND_SENSOR] = second_sensor_trip_i & config_q[CFG_SECOND_EN];
		events[BIT_MAIN_SENSOR]   = main_sensor_trip_i;
	end

	// Flags always set regardless of interrupt enables; set beats a same-cycle clear
	always_comb begin
		status_d = status_q;
		if (reg_wr_i && reg_addr_i == ADDR_STATUS) begin
			status_d = status_q & ~reg_wdata_i; // [R9]
		end
		status_d = (status_d | events) & EVENT_MASK; // [R1] [R3] [R4] [R5] [R6] [R7]
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			status_q <= RST_STATUS;
		end else begin
			status_q <= status_d;
		end
	end

	// Enable and configuration registers
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_en_q <= RST_IRQ_EN;
			config_q <= RST_CONFIG;
		end else if (reg_wr_i) begin
			if (reg_addr_i == ADDR_IRQ_EN) begin
				irq_en_q <= reg_wdata_i & EVENT_MASK; // Reserved bits stay zero
			end else if (reg_addr_i == ADDR_CONFIG) begin
				config_q <= reg_wdata_i;
			end
		end
	end

	// Interrupt computed from next flag state so output is registered yet current
	assign irq_d = |(status_d & irq_en_q); // [R8]

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			host_irq_o <= 1'b0;
		end else begin
			host_irq_o <= irq_d; // [R1] [R3] [R4] [R5] [R6] [R7] [R8]
		end
	end

	// Read data registered; reading never touches flags
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			if (reg_addr_i == ADDR_STATUS) begin
				reg_rdata_o <= status_q; // [R9]
			end else if (reg_addr_i == ADDR_IRQ_EN) begin
				reg_rdata_o <= irq_en_q;
			end else if (reg_addr_i == ADDR_CONFIG) begin
				reg_rdata_o <= config_q;
			end else begin
				reg_rdata_o <= 8'h00;
			end
		end
	end

	// Configuration decode, registered so every output is a flop
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			status_o                  <= RST_STATUS;
			sensor_source_select_o    <= 1'b0;
			second_sensor_enable_o    <= 1'b0;
			sixth_led_sink_enable_o   <= 1'b1;
			brightness_level_select_o <= 3'h0;
			backlight_off_o           <= 1'b0;
			dimming_transfer_law_o    <= 2'h0;
			fade_override_o           <= 1'b0;
		end else begin
			status_o                  <= status_d;
			sensor_source_select_o    <= config_q[CFG_SOURCE_SEL]; // [R10]
			second_sensor_enable_o    <= config_q[CFG_SECOND_EN]; // [R11]
			sixth_led_sink_enable_o   <= ~config_q[CFG_SECOND_EN]; // [R11]
			brightness_level_select_o <= config_q[CFG_LEVEL_HI:CFG_LEVEL_LO];
			backlight_off_o           <= config_q[CFG_LEVEL_HI:CFG_LEVEL_LO] > LEVEL_MAX; // [R12]
			dimming_transfer_law_o    <= config_q[CFG_LAW_HI:CFG_LAW_LO];
			fade_override_o           <= config_q[CFG_FADE_OVR];
		end
	end

	// Checks on the interrupt output and reserved register bits
	// The enable term is one cycle old: the output flop samples the enable before a write lands
	a_irq_follows_or: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R8]
		host_irq_o == |(status_o & $past(irq_en_q)))
		else $error("irq not OR of enabled flags");
	a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R8]
		(status_q & ~EVENT_MASK) == 8'h00 && (irq_en_q & ~EVENT_MASK) == 8'h00)
		else $error("reserved bits set");

	// Checks on flag setting and masking
	a_flags_ignore_en: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R1] [R3] [R4] [R5] [R6] [R7]
		1'b1 |=> (status_q & $past(events)) == $past(events))
		else $error("event did not set its flag");
	a_fade_sets_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R2]
		(auto_fade_done_i || profile_done_i) |=> status_q[BIT_FADE_DONE])
		else $error("fade done lost");
	a_fade_irq: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R1]
		((auto_fade_done_i || profile_done_i) && irq_en_q[BIT_FADE_DONE]) |=> host_irq_o)
		else $error("fade irq missing");
	a_short_irq: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R3]
		(short_fault_i && irq_en_q[BIT_SHORT]) |=> host_irq_o && status_q[BIT_SHORT])
		else $error("short irq missing");
	a_short_masked: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R3]
		(short_fault_i && irq_en_q == 8'h00) |=> status_q[BIT_SHORT] && !host_irq_o)
		else $error("short mask wrong");
	a_thermal_irq: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R4]
		(thermal_trip_i && irq_en_q[BIT_THERMAL]) |=> host_irq_o && status_q[BIT_THERMAL])
		else $error("thermal irq missing");
	a_thermal_masked: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R4]
		(thermal_trip_i && irq_en_q == 8'h00) |=> status_q[BIT_THERMAL] && !host_irq_o)
		else $error("thermal mask wrong");
	a_ovp_masked: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R5]
		(overvoltage_i && irq_en_q == 8'h00) |=> status_q[BIT_OVERVOLTAGE] && !host_irq_o)
		else $error("overvoltage mask wrong");
	a_second_irq: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R6]
		(second_sensor_trip_i && config_q[CFG_SECOND_EN] && irq_en_q[BIT_SECOND_SENSOR]) |=> host_irq_o)
		else $error("second sensor irq missing");
	a_second_refused: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R6]
		(second_sensor_trip_i && !config_q[CFG_SECOND_EN] && !status_q[BIT_SECOND_SENSOR])
		|=> !status_q[BIT_SECOND_SENSOR]) else $error("disabled second sensor set its flag");
	a_main_irq: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R7]
		(main_sensor_trip_i && irq_en_q[BIT_MAIN_SENSOR]) |=> host_irq_o && status_q[BIT_MAIN_SENSOR])
		else $error("main sensor irq missing");

	// Checks on flag clearing and register reads
	a_clear_one: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R9]
		(reg_wr_i && reg_addr_i == ADDR_STATUS && events == 8'h00) |=> (status_q & $past(reg_wdata_i)) == 8'h00)
		else $error("clear failed");
	a_keep_unwritten: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R9]
		(reg_wr_i && reg_addr_i == ADDR_STATUS)
		|=> ((status_q ^ ($past(status_q) | $past(events))) & ~$past(reg_wdata_i)) == 8'h00) else $error("zero cleared");
	a_set_beats_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R9]
		(reg_wr_i && reg_addr_i == ADDR_STATUS && (events & reg_wdata_i) != 8'h00)
		|=> (status_q & $past(events)) == $past(events)) else $error("clear beat a new event");
	a_read_keeps: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R9]
		(!reg_wr_i) |=> status_q == ($past(status_q) | $past(events)))
		else $error("flag changed on read");
	a_status_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R9]
		(reg_rd_i && reg_addr_i == ADDR_STATUS) |=> reg_rdata_o == $past(status_q))
		else $error("status read wrong");
	a_config_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R10]
		(reg_rd_i && reg_addr_i == ADDR_CONFIG) |=> reg_rdata_o == $past(config_q))
		else $error("config read wrong");
	a_unmapped_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(reg_rd_i && reg_addr_i != ADDR_STATUS && reg_addr_i != ADDR_IRQ_EN && reg_addr_i != ADDR_CONFIG)
		|=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");

	// Checks on configuration decode, one cycle behind the register
	a_source_sel: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R10]
		##1 sensor_source_select_o == $past(config_q[CFG_SOURCE_SEL]))
		else $error("source select wrong");
	a_sink_swap: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R11]
		sixth_led_sink_enable_o != second_sensor_enable_o)
		else $error("sink and sensor both on");
	a_sink_follows: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R11]
		##1 sixth_led_sink_enable_o == !$past(config_q[CFG_SECOND_EN]))
		else $error("sink enable wrong");
	a_level_field: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R12]
		##1 brightness_level_select_o == $past(config_q[CFG_LEVEL_HI:CFG_LEVEL_LO]))
		else $error("level field wrong");
	a_level_off: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R12]
		##1 backlight_off_o == ($past(config_q[CFG_LEVEL_HI:CFG_LEVEL_LO]) >= 3'h5))
		else $error("level off wrong");
endmodule // bli_irq_cfg
`default_nettype wire

// >>> tb/bli_host.sv
// Host model: byte register master of the backlight interrupt block.
// Assumes the block takes strobes on the rising edge of sys_clk_i.
`default_nettype none
module bli_host (
	input  wire logic       sys_clk_i,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus before the first access
	initial begin
		{reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
	end
	// Released fields go to inverse values so stale data cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		{reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b1, a, d};
		@(negedge sys_clk_i);
		{reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b0, ~a, ~d};
		@(negedge sys_clk_i);
	endtask
	// Read data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk_i);
		{reg_rd_o, reg_addr_o} = {1'b1, a};
		@(negedge sys_clk_i);
		d = reg_rdata_i;
		{reg_rd_o, reg_addr_o} = {1'b0, ~a};
	endtask
endmodule // bli_host
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the backlight interrupt and configuration block.
// Assumes the host model drives the register port; events come from here.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bli_pkg::*;
	logic       clk, rstn, wr, rd, irq, sel, s2en, sink, off, fovr;
	logic [7:0] addr, wdata, rdata, stat, v, c;
	logic [6:0] ev;
	logic [2:0] lvl;
	logic [1:0] law;
	int         n_errors, checks_done, b;
	bli_host u_bli_host (.sys_clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata));
	bli_irq_cfg u_bli_irq_cfg (.sys_clk_i(clk), .rstn_i(rstn), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .auto_fade_done_i(ev[5]),
		.profile_done_i(ev[6]), .short_fault_i(ev[4]), .thermal_trip_i(ev[3]), .overvoltage_i(ev[2]),
		.second_sensor_trip_i(ev[1]), .main_sensor_trip_i(ev[0]), .host_irq_o(irq), .status_o(stat),
		.sensor_source_select_o(sel), .second_sensor_enable_o(s2en), .sixth_led_sink_enable_o(sink),
		.brightness_level_select_o(lvl), .backlight_off_o(off), .dimming_transfer_law_o(law),
		.fade_override_o(fovr));
	// Free-running clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	// One-cycle event pulse, results looked at once the edge has landed
	task automatic pulse(input int s);
		@(negedge clk);
		ev[s] = 1'b1;
		@(negedge clk);
		ev = '0;
	endtask
	task automatic test_done;
		$display("mismatches %0d, checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog sized well above the roughly two hundred cycles the tests need
	initial begin
		#100us;
		n_errors++;
		test_done();
	end
	initial begin
		{rstn, ev, n_errors, checks_done} = '0;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		chk("sink", 8'h01, {7'h00, sink});
		u_bli_host.rd(ADDR_IRQ_EN, v);
		chk("enable", 8'h00, v);
		u_bli_host.rd(8'h10, v);
		chk("unmapped", 8'h00, v);
		// Second sensor trips only count while that sensor is enabled
		pulse(1);
		chk("refused", 8'h00, stat);
		u_bli_host.wr(ADDR_CONFIG, 8'h40);
		for (int s = 0; s < 7; s++) begin
			b = (s == 6) ? 5 : s;
			pulse(s);
			chk("flag", 8'h01 << b, stat);
			chk("masked", 8'h00, {7'h00, irq});
			u_bli_host.wr(ADDR_IRQ_EN, 8'h01 << b);
			chk("irq", 8'h01, {7'h00, irq});
			u_bli_host.wr(ADDR_STATUS, ~(8'h01 << b));
			u_bli_host.rd(ADDR_STATUS, v);
			chk("kept", 8'h01 << b, v);
			u_bli_host.wr(ADDR_STATUS, 8'h01 << b);
			chk("cleared", 8'h00, stat);
			chk("irq low", 8'h00, {7'h00, irq});
			u_bli_host.wr(ADDR_IRQ_EN, 8'h00);
		end
		u_bli_host.wr(ADDR_IRQ_EN, 8'hFF);
		u_bli_host.rd(ADDR_IRQ_EN, v);
		chk("reserved", EVENT_MASK, v);
		// A write to an unmapped address must leave the configuration alone
		u_bli_host.wr(8'h10, 8'hFF);
		u_bli_host.rd(ADDR_CONFIG, v);
		chk("config kept", 8'h40, v);
		// An event in the same cycle as its clear must win
		fork
			pulse(4);
			u_bli_host.wr(ADDR_STATUS, 8'h10);
		join
		chk("set wins", 8'h10, stat);
		chk("irq kept", 8'h01, {7'h00, irq});
		u_bli_host.wr(ADDR_STATUS, 8'h10);
		chk("cleared again", 8'h00, stat);
		for (int k = 0; k < 8; k++) begin
			c = {k[2:0], k[2:0], k[1:0]};
			u_bli_host.wr(ADDR_CONFIG, c);
			u_bli_host.rd(ADDR_CONFIG, v);
			chk("config", c, v);
			chk("select", {5'h00, c[7], c[6], ~c[6]}, {5'h00, sel, s2en, sink});
			chk("level", {1'b0, c[5:3], c[2:0], c[5:3] > 3'h4}, {1'b0, lvl, law, fovr, off});
		end
		// Mid-run reset with a flag, the enables and the configuration all set
		pulse(0);
		chk("irq before reset", 8'h01, {7'h00, irq});
		@(negedge clk);
		rstn = 1'b0;
		@(negedge clk);
		chk("reset irq", 8'h00, {7'h00, irq});
		chk("reset status", 8'h00, stat);
		chk("reset select", 8'h01, {5'h00, sel, s2en, sink});
		chk("reset level", 8'h00, {1'b0, lvl, law, fovr, off});
		rstn = 1'b1;
		u_bli_host.rd(ADDR_CONFIG, v);
		chk("reset config", 8'h00, v);
		u_bli_host.rd(ADDR_IRQ_EN, v);
		chk("reset enable", 8'h00, v);
		u_bli_host.rd(ADDR_STATUS, v);
		chk("reset flags", 8'h00, v);
		test_done();
	end
endmodule // testbench
`default_nettype wire
